// >>> imf_pkg.sv
// How it works
// - Mask bits read and write; one enables
// - Reset clears every mask bit
// - Timer masks gate timer flags, same bits
// - Converter mask gates converter done flag
// - One mask bit per input pin
// - Pins share one read-only flag
// - Flags clear on read; writes ignored
// - Unused bits read as zero
// - Accept pushes next address onto stack
// - Then vector from page one loads
// - Core fetches at vector after load
// - Push plus vector load take twelve cycles
// - Flag sets always; request needs mask
// - Interrupt needs flag, mask, global enable
// - Accept clears the global enable
// - Pending request wakes a halted core
// - Timer flags set on falling edges
package imf_pkg;
  localparam logic [7:0]  PIN_MASK_ADDR   = 8'hE8;
  localparam logic [7:0]  TIMER_MASK_ADDR = 8'hEB;
  localparam logic [7:0]  CONV_MASK_ADDR  = 8'hEC;
  localparam logic [7:0]  PIN_FLAG_ADDR   = 8'hED;
  localparam logic [7:0]  TIMER_FLAG_ADDR = 8'hEF;
  localparam logic [7:0]  CONV_FLAG_ADDR  = 8'hF0;
  localparam logic [7:0]  GLOBAL_EN_ADDR  = 8'hF8;
  localparam int          DATA_W          = 4;
  localparam int          PC_W            = 12;
  localparam int          TIMER_SLOW_BIT  = 2;
  localparam int          TIMER_MID_BIT   = 1;
  localparam int          TIMER_FAST_BIT  = 0;
  localparam int          CONV_DONE_BIT   = 0;
  localparam int          PIN_FLAG_BIT    = 0;
  localparam int          GLOBAL_EN_BIT   = 0;
  localparam logic [3:0]  MASK_RESET      = 4'h0;
  localparam logic [3:0]  FLAG_RESET      = 4'h0;
  localparam int          SEQ_CYCLES      = 12;
  localparam int          PUSH_NIBBLES    = 3;
  localparam logic [3:0]  VEC_PAGE        = 4'h1;
  localparam logic [7:0]  VEC_PIN         = 8'h02;
  localparam logic [7:0]  VEC_CONV        = 8'h04;
  localparam logic [7:0]  VEC_TIMER       = 8'h06;
endpackage

// >>> imf_fall_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser with a falling-edge pulse per bit
module imf_fall_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock_i,  // System clock
  input  wire logic             rstn_i,   // Async reset, active low
  input  wire logic [WIDTH-1:0] level_i,  // Asynchronous levels
  output logic      [WIDTH-1:0] fall_o    // One-cycle pulse on 1->0
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] last;

  // Refused at elaboration: a zero-width edge detector has nothing to watch
  if (WIDTH < 1)
  begin : g_width_check
    $error("imf_fall_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end
    else
    begin
      meta <= level_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign fall_o = last & ~sync;
endmodule

// >>> imf_vector_seq.sv
`timescale 1ns/10ps
// Return-address push and vector load, fixed length
module imf_vector_seq (
  input  wire logic        clock_i,     // System clock
  input  wire logic        rstn_i,      // Async reset, active low
  input  wire logic        start_i,     // Accept pulse
  input  wire logic [11:0] ret_pc_i,    // Address of next instruction
  input  wire logic [11:0] vector_i,    // Vector to load
  output logic             busy_o,      // Sequence running
  output logic             push_o,      // Stack write strobe
  output logic [1:0]       push_idx_o,  // Nibble index, low first
  output logic [3:0]       push_nib_o,  // Nibble written to stack
  output logic             pc_load_o,   // Program counter load strobe
  output logic [11:0]      pc_vector_o  // Value to load
);
  typedef enum logic {IMF_IDLE, IMF_RUN} imf_seq_t;
  imf_seq_t    state;
  logic [3:0]  count;
  logic [11:0] ret_pc;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state       <= IMF_IDLE;
      count       <= 4'h0;
      ret_pc      <= 12'h000;
      pc_vector_o <= 12'h000;
    end
    else
    begin
      case (state)
        IMF_IDLE:
        begin
          count <= 4'h0;
          if (start_i)
          begin
            state       <= IMF_RUN;
            ret_pc      <= ret_pc_i;
            pc_vector_o <= vector_i;
          end
        end
        IMF_RUN:
        begin
          if (count == 4'(imf_pkg::SEQ_CYCLES - 1))
            state <= IMF_IDLE;
          count <= count + 4'h1;
        end
        default:
          state <= IMF_IDLE;
      endcase
    end
  end

  assign busy_o     = (state == IMF_RUN);
  assign push_o     = busy_o && (count < 4'(imf_pkg::PUSH_NIBBLES));
  assign push_idx_o = count[1:0];
  assign push_nib_o = (count[1:0] == 2'h0) ? ret_pc[3:0] :
                      (count[1:0] == 2'h1) ? ret_pc[7:4] : ret_pc[11:8];
  assign pc_load_o  = busy_o && (count == 4'(imf_pkg::SEQ_CYCLES - 1));
endmodule

// >>> imf_unit.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
// Interrupt masks, read-clear factor flags and vectoring
module imf_unit (
  input  wire logic        clock_i,        // System clock, 25 MHz
  input  wire logic        rstn_i,         // Async reset, active low
  input  wire logic [7:0]  addr_i,         // Register address
  input  wire logic [3:0]  wdata_i,        // Write data
  input  wire logic        wr_i,           // Write strobe
  input  wire logic        rd_i,           // Read strobe
  output logic      [3:0]  rdata_o,        // Read data, cycle after strobe
  input  wire logic        timer_slow_i,   // 2 Hz timer signal
  input  wire logic        timer_mid_i,    // 8 Hz timer signal
  input  wire logic        timer_fast_i,   // 32 Hz timer signal
  input  wire logic        conv_done_i,    // Conversion finished pulse
  input  wire logic [3:0]  pin_event_i,    // Input pin edge pulses
  input  wire logic        set_ei_i,       // Core sets global enable
  input  wire logic        set_di_i,       // Core clears global enable
  input  wire logic        boundary_i,     // Core at instruction boundary
  input  wire logic        halted_i,       // Core halted, clock stopped
  input  wire logic [11:0] next_pc_i,      // Address of next instruction
  output logic             irq_req_o,      // Request toward core
  output logic             wake_o,         // Restart halted clock
  output logic             busy_o,         // Vectoring in progress
  output logic             push_o,         // Stack write strobe
  output logic      [1:0]  push_idx_o,     // Stack nibble index
  output logic      [3:0]  push_nib_o,     // Stack nibble
  output logic             pc_load_o,      // Load program counter
  output logic      [11:0] pc_vector_o,    // Vector address
  output logic             global_irq_enabled_o // Global enable flag
);
  logic [3:0] pin_masks;
  logic [2:0] timer_masks;
  logic       conv_mask;
  logic [2:0] timer_flags;
  logic       conv_flag;
  logic       pin_flag;
  logic       global_irq_enabled;
  logic [2:0] timer_fall;
  logic       pin_hit;
  logic       pend_timer;
  logic       pend_conv;
  logic       pend_pin;
  logic       any_pend;
  logic       accept;
  logic [11:0] next_vector;
  logic [3:0] next_rdata;
  logic       wr_hit_pin;
  logic       wr_hit_timer;
  logic       wr_hit_conv;
  logic       rd_timer;
  logic       rd_conv;
  logic       rd_pin;

  assign wr_hit_pin   = wr_i && (addr_i == imf_pkg::PIN_MASK_ADDR);
  assign wr_hit_timer = wr_i && (addr_i == imf_pkg::TIMER_MASK_ADDR);
  assign wr_hit_conv  = wr_i && (addr_i == imf_pkg::CONV_MASK_ADDR);
  assign rd_timer     = rd_i && (addr_i == imf_pkg::TIMER_FLAG_ADDR);
  assign rd_conv      = rd_i && (addr_i == imf_pkg::CONV_FLAG_ADDR);
  assign rd_pin       = rd_i && (addr_i == imf_pkg::PIN_FLAG_ADDR);

  imf_fall_sync #(
    .WIDTH (3)
  ) u_timer_edges (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .level_i ({timer_slow_i, timer_mid_i, timer_fast_i}),
    .fall_o  (timer_fall)
  );

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_masks   <= imf_pkg::MASK_RESET;
      timer_masks <= imf_pkg::MASK_RESET[2:0];
      conv_mask   <= imf_pkg::MASK_RESET[0];
    end
    else
    begin
      if (wr_hit_pin)
        pin_masks <= wdata_i;
      if (wr_hit_timer)
        timer_masks <= wdata_i[2:0];
      if (wr_hit_conv)
        conv_mask <= wdata_i[imf_pkg::CONV_DONE_BIT];
    end
  end

  // Read clears, set wins over clear
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      timer_flags <= imf_pkg::FLAG_RESET[2:0];
      conv_flag   <= imf_pkg::FLAG_RESET[0];
      pin_flag    <= imf_pkg::FLAG_RESET[0];
    end
    else
    begin
      timer_flags <= (rd_timer ? 3'h0 : timer_flags) | timer_fall;
      conv_flag   <= (rd_conv ? 1'b0 : conv_flag) | conv_done_i;
      pin_flag    <= (rd_pin ? 1'b0 : pin_flag) | pin_hit;
    end
  end

  assign pin_hit = |pin_event_i;

  assign pend_timer = |(timer_flags & timer_masks);
  assign pend_conv  = conv_flag & conv_mask;
  // Any pin event counts once enabled on any pin
  assign pend_pin   = pin_flag & (|pin_masks);
  assign any_pend   = pend_timer | pend_conv | pend_pin;

  assign irq_req_o = global_irq_enabled && any_pend && !busy_o;
  assign accept    = irq_req_o && boundary_i;
  assign wake_o    = halted_i && any_pend;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      global_irq_enabled <= 1'b0;
    else if (accept || set_di_i)
      global_irq_enabled <= 1'b0;
    else if (set_ei_i || (wr_i && (addr_i == imf_pkg::GLOBAL_EN_ADDR)
                          && wdata_i[imf_pkg::GLOBAL_EN_BIT]))
      global_irq_enabled <= 1'b1;
  end

  assign global_irq_enabled_o = global_irq_enabled;

  always_comb
  begin
    if (pend_pin)
      next_vector = {imf_pkg::VEC_PAGE, imf_pkg::VEC_PIN};
    else if (pend_conv)
      next_vector = {imf_pkg::VEC_PAGE, imf_pkg::VEC_CONV};
    else
      next_vector = {imf_pkg::VEC_PAGE, imf_pkg::VEC_TIMER};
  end

  // Core fetches at vector after load
  imf_vector_seq u_seq (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .start_i     (accept),
    .ret_pc_i    (next_pc_i),
    .vector_i    (next_vector),
    .busy_o      (busy_o),
    .push_o      (push_o),
    .push_idx_o  (push_idx_o),
    .push_nib_o  (push_nib_o),
    .pc_load_o   (pc_load_o),
    .pc_vector_o (pc_vector_o)
  );

  always_comb
  begin
    next_rdata = 4'h0;
    case (addr_i)
      imf_pkg::PIN_MASK_ADDR:   next_rdata = pin_masks;
      imf_pkg::TIMER_MASK_ADDR: next_rdata = {1'b0, timer_masks};
      imf_pkg::CONV_MASK_ADDR:  next_rdata = {3'h0, conv_mask};
      imf_pkg::PIN_FLAG_ADDR:   next_rdata = {3'h0, pin_flag};
      imf_pkg::TIMER_FLAG_ADDR: next_rdata = {1'b0, timer_flags};
      imf_pkg::CONV_FLAG_ADDR:  next_rdata = {3'h0, conv_flag};
      imf_pkg::GLOBAL_EN_ADDR:  next_rdata = {3'h0, global_irq_enabled};
      default:                  next_rdata = 4'h0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 4'h0;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 4'h0;
  end

  a_mask_write_store: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    wr_hit_pin |=> pin_masks == $past(wdata_i))
    else $error("pin mask write not stored");

  a_flag_read_clear: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    rd_timer && (timer_fall == 3'h0) |=> timer_flags == 3'h0)
    else $error("timer flags not cleared by read");

  a_reserved_bits_zero: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    rd_i && (addr_i == imf_pkg::TIMER_MASK_ADDR) |=> rdata_o[3] == 1'b0)
    else $error("reserved bit read nonzero");

  a_request_needs_all: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    irq_req_o |-> global_irq_enabled && (((timer_flags & timer_masks) != 3'h0)
      || (conv_flag && conv_mask) || (pin_flag && (pin_masks != 4'h0))))
    else $error("request without enable and pending flag");

  a_masked_no_request: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    (timer_masks == 3'h0) && !conv_mask && (pin_masks == 4'h0) |-> !irq_req_o)
    else $error("request raised while all masked");

  a_accept_clears_ei: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    accept |=> !global_irq_enabled)
    else $error("global enable not cleared on accept");

  a_push_then_load: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    accept |=> push_o ##11 pc_load_o)
    else $error("vector load not twelve cycles after accept");

  a_halt_wake: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    halted_i && any_pend |-> wake_o)
    else $error("halted core not woken");

  a_timer_fall_flag: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    timer_fall[imf_pkg::TIMER_SLOW_BIT] |=> timer_flags[imf_pkg::TIMER_SLOW_BIT])
    else $error("slow timer flag not set on falling edge");

  a_pin_flag_set: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    pin_hit |=> pin_flag)
    else $error("pin flag not set by pin event");

  a_timer_mask_store: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    wr_hit_timer |=> timer_masks == $past(wdata_i[2:0]))
    else $error("timer mask write not stored");

  a_conv_mask_store: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    wr_hit_conv |=> conv_mask == $past(wdata_i[imf_pkg::CONV_DONE_BIT]))
    else $error("converter mask write not stored");

  a_conv_read_clear: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    rd_conv && !conv_done_i |=> !conv_flag)
    else $error("converter flag not cleared by read");

  a_pin_read_clear: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    rd_pin && !pin_hit |=> !pin_flag)
    else $error("pin flag not cleared by read");

  a_flag_write_ignored: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    wr_i && (addr_i == imf_pkg::TIMER_FLAG_ADDR) && (timer_fall == 3'h0)
      |=> $stable(timer_flags))
    else $error("timer flags changed by a write");

  a_conv_set_unmasked: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    conv_done_i |=> conv_flag)
    else $error("converter flag not set by completion");

  a_timer_gate: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    ((timer_flags & timer_masks) == 3'h0) && !(conv_flag && conv_mask)
      && !(pin_flag && (pin_masks != 4'h0)) |-> !irq_req_o)
    else $error("request without an enabled pending flag");

  a_no_req_disabled: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    !global_irq_enabled |-> !irq_req_o)
    else $error("request while global enable clear");

  a_ei_sets_enable: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    set_ei_i && !set_di_i && !accept |=> global_irq_enabled)
    else $error("global enable not set by core");

  a_push_low_first: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    accept |=> push_o && (push_idx_o == 2'h0) && (push_nib_o == $past(next_pc_i[3:0])))
    else $error("return address low nibble not pushed first");

  a_vector_page_one: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    pc_load_o |-> pc_vector_o[11:8] == imf_pkg::VEC_PAGE)
    else $error("vector outside page one");

  a_pin_first: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    accept && pin_flag && (pin_masks != 4'h0)
      |=> pc_vector_o == {imf_pkg::VEC_PAGE, imf_pkg::VEC_PIN})
    else $error("pin request not given its vector");

  a_busy_span: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    accept |=> busy_o ##11 busy_o ##1 !busy_o)
    else $error("vectoring not twelve cycles long");
endmodule

// >>> imf_core_model.sv
`timescale 1ns/10ps
// Processor core stand-in: offers instruction boundaries, tracks the next address
module imf_core_model (
  input  wire logic        clock_i,     // System clock
  input  wire logic        rstn_i,      // Async reset, active low
  input  wire logic        slow_i,      // Boundary only every fourth cycle
  input  wire logic        busy_i,      // Vectoring in progress
  input  wire logic        pc_load_i,   // Program counter load strobe
  input  wire logic [11:0] pc_vector_i, // Vector address
  output logic             boundary_o,  // Instruction boundary
  output logic      [11:0] next_pc_o    // Address of next instruction
);
  logic [1:0] slot;

  assign boundary_o = !busy_i && (!slow_i || slot == 2'h0);

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      slot      <= 2'h0;
      next_pc_o <= 12'h000;
    end
    else
    begin
      slot <= slot + 2'h1;
      if (pc_load_i)
        next_pc_o <= pc_vector_i + 12'h001;
      else if (boundary_o)
        next_pc_o <= next_pc_o + 12'h3B7;
    end
  end
endmodule

// >>> imf_unit_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module imf_unit_tb;
  logic        clock_i, rstn_i, wr_i, rd_i, conv_done_i, set_ei_i, set_di_i, halted_i, slow;
  logic [7:0]  addr_i;
  logic [3:0]  wdata_i, pin_event_i, rdata_o, d, e4;
  logic [2:0]  tmr;
  logic        irq_req_o, wake_o, busy_o, push_o, pc_load_o, global_irq_enabled_o, boundary;
  logic [1:0]  push_idx_o;
  logic [3:0]  push_nib_o;
  logic [11:0] pc_vector_o, next_pc, stk, ret_pc, e12;
  logic [3:0]  exp_rd[$];
  logic [11:0] exp_vec[$];
  logic        rd_d;
  int          n_errors, checks, cnt;
  int          seed = 60937;
  localparam logic [7:0] ADDRS [7] = '{8'hE8, 8'hEB, 8'hEC, 8'hED, 8'hEF, 8'hF0, 8'h00};
  localparam logic [7:0] CLRS [3] = '{8'hED, 8'hF0, 8'hEF};

  imf_unit u_imf_unit (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_slow_i(tmr[2]), .timer_mid_i(tmr[1]), .timer_fast_i(tmr[0]),
    .conv_done_i(conv_done_i), .pin_event_i(pin_event_i), .set_ei_i(set_ei_i),
    .set_di_i(set_di_i), .boundary_i(boundary), .halted_i(halted_i), .next_pc_i(next_pc),
    .irq_req_o(irq_req_o), .wake_o(wake_o), .busy_o(busy_o), .push_o(push_o),
    .push_idx_o(push_idx_o), .push_nib_o(push_nib_o), .pc_load_o(pc_load_o),
    .pc_vector_o(pc_vector_o), .global_irq_enabled_o(global_irq_enabled_o));

  imf_core_model u_imf_core_model (.clock_i(clock_i), .rstn_i(rstn_i), .slow_i(slow),
    .busy_i(busy_o), .pc_load_i(pc_load_o), .pc_vector_i(pc_vector_o),
    .boundary_o(boundary), .next_pc_o(next_pc));

  task automatic summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [3:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [3:0] v);
    @(posedge clock_i);
    exp_rd.push_back(v);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
  endtask

  task automatic ev(input logic [3:0] p, input logic c, input logic e, input logic x);
    @(posedge clock_i);
    pin_event_i <= p;
    conv_done_i <= c;
    set_ei_i    <= e;
    set_di_i    <= x;
    @(posedge clock_i);
    pin_event_i <= 4'h0;
    conv_done_i <= 1'b0;
    set_ei_i    <= 1'b0;
    set_di_i    <= 1'b0;
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clock_i);
      if (i > 0 && !busy_o && !irq_req_o)
        break;
    end
  endtask

  // Read results a cycle after the strobe; vectoring checked at the load strobe
  always @(posedge clock_i)
  begin
    if (rd_d)
    begin
      e4 = exp_rd.pop_front();
      `CHK("rdata", e4, rdata_o)
    end
    rd_d = rd_i;
    if (cnt >= 0)
      cnt++;
    if (push_o)
      stk[push_idx_o*4 +: 4] = push_nib_o;
    if (pc_load_o)
    begin
      e12 = exp_vec.pop_front();
      `CHK("cycles", 12, cnt)
      `CHK("stack", ret_pc, stk)
      `CHK("vector", e12, pc_vector_o)
      cnt = -1;
    end
    if (irq_req_o && boundary)
    begin
      ret_pc = next_pc;
      stk    = ~next_pc;
      cnt    = 0;
    end
  end

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  initial
  begin
    repeat (5000) @(posedge clock_i);
    n_errors++;
    summarize();
  end

  initial
  begin
    {rstn_i, wr_i, rd_i, conv_done_i, set_ei_i, set_di_i, halted_i, slow, rd_d} = '0;
    {addr_i, wdata_i, pin_event_i, tmr} = '0;
    cnt = -1;
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    foreach (ADDRS[i]) reg_rd(ADDRS[i], 4'h0);
    reg_wr(8'hEF, 4'hF);
    reg_rd(8'hEF, 4'h0);
    for (int i = 0; i < 4; i++)
    begin
      d = 4'($random(seed));
      reg_wr(8'hE8, d);
      reg_wr(8'hEB, d);
      reg_wr(8'hEC, d);
      reg_rd(8'hE8, d);
      reg_rd(8'hEB, d & 4'h7);
      reg_rd(8'hEC, d & 4'h1);
    end
    reg_wr(8'hE8, 4'h0);
    reg_wr(8'hEB, 4'h0);
    reg_wr(8'hEC, 4'h0);
    reg_wr(8'hF8, 4'h1);
    for (int b = 0; b < 3; b++)
    begin
      tmr[b] <= 1'b1;
      repeat (5) @(posedge clock_i);
      reg_rd(8'hEF, 4'h0);
      tmr[b] <= 1'b0;
      repeat (5) @(posedge clock_i);
      reg_rd(8'hEF, 4'h1 << b);
    end
    ev(4'h8, 1'b1, 1'b0, 1'b0);
    @(negedge clock_i);
    `CHK("irq_req", 1'b0, irq_req_o)
    reg_rd(8'hED, 4'h1);
    reg_rd(8'hF0, 4'h1);
    reg_rd(8'hED, 4'h0);
    reg_rd(8'hF0, 4'h0);
    ev(4'h0, 1'b0, 1'b0, 1'b1);
    reg_wr(8'hE8, 4'h4);
    reg_wr(8'hEB, 4'h1);
    reg_wr(8'hEC, 4'h1);
    ev(4'h4, 1'b1, 1'b0, 1'b0);
    tmr[0] <= 1'b1;
    repeat (5) @(posedge clock_i);
    tmr[0]   <= 1'b0;
    halted_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    `CHK("irq_req", 1'b0, irq_req_o)
    `CHK("wake", 1'b1, wake_o)
    halted_i <= 1'b0;
    exp_vec = '{12'h102, 12'h104, 12'h106};
    for (int k = 0; k < 3; k++)
    begin
      slow <= k[0];
      if (k == 0)
        reg_wr(8'hF8, 4'h1);
      else
        ev(4'h0, 1'b0, 1'b1, 1'b0);
      wait_idle();
      `CHK("global_en", 1'b0, global_irq_enabled_o)
      reg_rd(CLRS[k], 4'h1);
    end
    ev(4'h0, 1'b0, 1'b1, 1'b0);
    @(negedge clock_i);
    `CHK("global_en", 1'b1, global_irq_enabled_o)
    `CHK("irq_req", 1'b0, irq_req_o)
    `CHK("wake", 1'b0, wake_o)
    ev(4'h0, 1'b0, 1'b1, 1'b1);
    @(negedge clock_i);
    `CHK("global_en", 1'b0, global_irq_enabled_o)
    repeat (3) @(posedge clock_i);
    `CHK("pending", 0, exp_vec.size() + exp_rd.size())
    summarize();
  end
endmodule
